// ===== cbt_pkg.sv
// constants, opcodes and states shared by the bit/transfer/control core
// assumes a single 20 MHz system clock and an AHB-Lite register port
package cbt_pkg;
	// ---------------------------------------------------------------
	// register map, byte offsets on the bus
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_INSTR = 8'h00;
	localparam logic [7:0] ADR_OPERAND = 8'h04;
	localparam logic [7:0] ADR_FLAGS = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0c;
	localparam logic [7:0] ADR_SP = 8'h10;
	// working registers sit at 0x80 + 4*n
	localparam int GPR_SEL_BIT = 7;
	localparam int GPR_IDX_LSB = 2;
	localparam int HTRANS_ACT_BIT = 1;
	// ---------------------------------------------------------------
	// flags register bit positions
	// ---------------------------------------------------------------
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	// ---------------------------------------------------------------
	// instruction word fields
	// ---------------------------------------------------------------
	localparam int OP_W = 5;
	localparam int INSTR_W = 28;
	localparam int F_OP_LSB = 0;
	localparam int F_RD_LSB = 8;
	localparam int F_RR_LSB = 16;
	localparam int F_BIT_LSB = 21;
	localparam int F_PTR_LSB = 24;
	localparam int F_MODE_LSB = 26;
	localparam int Q_W = 6;
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [1:0] PTR_Z_SEL = 2'h2;
	localparam logic [1:0] AM_PLAIN = 2'h0;
	localparam logic [1:0] AM_POSTINC = 2'h1;
	localparam logic [1:0] AM_PREDEC = 2'h2;
	localparam int PMR_INC_BIT = 0;
	localparam int PMR_R0_BIT = 1;
	localparam logic [4:0] R0_IDX = 5'h00;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	localparam logic [15:0] SP_RST_DEF = 16'h01ff;
	// ---------------------------------------------------------------
	// opcodes and sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_SSHR = 5'h01, OP_SWAP = 5'h02,
		OP_FSET = 5'h03, OP_FCLR = 5'h04, OP_B2T = 5'h05,
		OP_T2B = 5'h06, OP_CPY = 5'h07, OP_CPYW = 5'h08,
		OP_IRD = 5'h09, OP_DRD = 5'h0a, OP_IWR = 5'h0b,
		OP_DWR = 5'h0c, OP_ARD = 5'h0d, OP_AWR = 5'h0e,
		OP_PMR = 5'h0f, OP_PUSH = 5'h10, OP_POP = 5'h11,
		OP_SLEEP = 5'h12, OP_WDOG = 5'h13, OP_BREAK = 5'h14
	} cbt_op_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00, S_ISSUE = 2'b01,
		S_ACCESS = 2'b10, S_FETCH = 2'b11
	} cbt_state_t;
endpackage

// ===== cbt_alu_if.sv
// operand and result bundle between the sequencer and the bit unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface cbt_alu_if;
	import cbt_pkg::*;
	cbt_op_t op; // operation being issued
	logic [7:0] dst; // destination register value
	logic [7:0] src; // source register value
	logic [2:0] bsel; // bit or flag index
	logic [7:0] flags_in; // current flags
	logic [7:0] result; // new destination value
	logic [7:0] flags_out; // new flags
	modport core (output op, dst, src, bsel, flags_in,
		input result, flags_out);
	modport alu (input op, dst, src, bsel, flags_in,
		output result, flags_out);
endinterface
`default_nettype wire

// ===== cbt_alu.sv
// single-cycle bit, flag and register-move unit, purely combinational
// assumes the caller registers result and flags on the issue edge
`timescale 1ns/1ps
`default_nettype none
module cbt_alu (
	cbt_alu_if.alu alu
);
	import cbt_pkg::*;

	// ---------------------------------------------------------------
	// operation decode
	// ---------------------------------------------------------------
	// defaults pass everything through so unlisted ops touch nothing
	always_comb begin
		alu.result = alu.dst;
		alu.flags_out = alu.flags_in;
		case (alu.op)
			OP_SSHR: begin
				// bit 7 is kept, old bit 0 leaves into carry
				alu.result = {alu.dst[7], alu.dst[7:1]}; // RQ20
				alu.flags_out[FL_C] = alu.dst[0];
				alu.flags_out[FL_Z] = (alu.dst[7:1] == 7'h00) &&
					!alu.dst[7];
				alu.flags_out[FL_N] = alu.dst[7];
				// overflow is negative xor carry after the shift
				alu.flags_out[FL_V] = alu.dst[7] ^ alu.dst[0];
			end
			OP_SWAP: begin
				alu.result = {alu.dst[3:0], alu.dst[7:4]}; // RQ21
			end
			OP_FSET: begin
				// one generic path serves overflow, sign, half carry
				alu.flags_out[alu.bsel] = 1'b1; // RQ3 RQ4 RQ5 RQ23
			end
			OP_FCLR: begin
				alu.flags_out[alu.bsel] = 1'b0; // RQ3 RQ4 RQ5 RQ23
			end
			OP_B2T: begin
				alu.flags_out[FL_T] = alu.src[alu.bsel]; // RQ1
			end
			OP_T2B: begin
				alu.result[alu.bsel] = alu.flags_in[FL_T]; // RQ2
			end
			OP_CPY: begin
				alu.result = alu.src; // RQ22
			end
			default: begin
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== cbt_core.sv
// bit, transfer and control execution core with AHB-Lite register port
// assumes an async-read data memory and a one-cycle program memory,
// both on hclk; software writes an instruction word to launch it
//
// Function
// [RQ1] bit-to-flag copies register bit into T
// [RQ2] flag-to-bit writes T into register bit
// [RQ3] overflow flag set/clear, one cycle
// [RQ4] signed test flag set/clear, one cycle
// [RQ5] half carry set/clear, one cycle
// [RQ6] indirect read then pointer increment, two cycles
// [RQ7] pointer decrement then indirect read, two cycles
// [RQ8] displaced read, pointer unchanged, two cycles
// [RQ9] indirect write then pointer increment
// [RQ10] pointer decrement then indirect write
// [RQ11] displaced write, pointer unchanged
// [RQ12] direct read from operand address, two cycles
// [RQ13] direct write to operand address, two cycles
// [RQ14] program-memory read via Z, three cycles
// [RQ15] stack save in two cycles, flags kept
// [RQ16] stack restore in two cycles, flags kept
// [RQ17] sleep issues in one cycle to power logic
// [RQ18] watchdog restart pulse in one cycle
// [RQ19] debug break only signals debug logic
// [RQ20] signed right shift keeps bit seven
// [RQ21] nibble exchange, no flag change
// [RQ22] register and register-pair copy, one cycle
// [RQ23] global interrupt enable set/clear, one cycle
`timescale 1ns/1ps
`default_nettype none
module cbt_core #(
	parameter logic [15:0] SP_RST = cbt_pkg::SP_RST_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [15:0] dm_addr,
	output logic [7:0] dm_wdata,
	output logic dm_we,
	output logic dm_re,
	input wire logic [7:0] dm_rdata,
	output logic [15:0] pm_addr,
	output logic pm_re,
	input wire logic [7:0] pm_rdata,
	output logic sleep_req,
	output logic wdt_restart,
	output logic debug_break
);
	import cbt_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] gpr [32]; // working registers
	logic [7:0] flags_reg; // flags register
	logic [15:0] sp_reg; // stack pointer
	logic [INSTR_W-1:0] instr_reg; // launched instruction word
	logic [15:0] operand_reg; // address or displacement operand
	cbt_state_t state_reg; // sequencer
	logic wr_pend_reg; // bus write in data phase
	logic [7:0] wr_addr_reg; // its address
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic [15:0] dm_addr_reg;
	logic [7:0] dm_wdata_reg;
	logic dm_we_reg;
	logic dm_re_reg;
	logic [15:0] pm_addr_reg;
	logic pm_re_reg;
	logic sleep_reg;
	logic wdt_reg;
	logic brk_reg;

	// ---------------------------------------------------------------
	// instruction fields and derived values
	// ---------------------------------------------------------------
	cbt_op_t op;
	logic [4:0] rd, rr, ptr_idx;
	logic [2:0] bsel;
	logic [1:0] psel, mode;
	logic [15:0] ptr, ptr_next, eff_addr, q_ext;
	logic is_dread, is_dwrite, is_flagop, busy;
	logic issue, start, acc, bus_wr_ok;
	logic [31:0] rd_mux;
	logic we0; // byte write-back
	logic [4:0] wa0;
	logic [7:0] wd0;
	logic pw_we; // register-pair write-back
	logic [4:0] pw_idx;
	logic [15:0] pw_data;

	assign op = cbt_op_t'(instr_reg[F_OP_LSB +: OP_W]);
	assign rd = instr_reg[F_RD_LSB +: 5];
	assign rr = instr_reg[F_RR_LSB +: 5];
	assign bsel = instr_reg[F_BIT_LSB +: 3];
	assign mode = instr_reg[F_MODE_LSB +: 2];
	// program-memory reads always go through Z
	assign psel = (op == OP_PMR) ? PTR_Z_SEL : instr_reg[F_PTR_LSB +: 2];
	assign ptr_idx = PTR_X_LO + {2'b00, psel, 1'b0};
	assign ptr = {gpr[{ptr_idx[4:1], 1'b1}], gpr[ptr_idx]};
	assign q_ext = 16'(operand_reg[Q_W-1:0]);
	assign busy = (state_reg != S_IDLE);
	assign issue = (state_reg == S_ISSUE);
	assign is_dread = (op == OP_IRD) || (op == OP_DRD) ||
		(op == OP_ARD) || (op == OP_POP);
	assign is_dwrite = (op == OP_IWR) || (op == OP_DWR) ||
		(op == OP_AWR) || (op == OP_PUSH);
	assign is_flagop = (op == OP_SSHR) || (op == OP_FSET) ||
		(op == OP_FCLR) || (op == OP_B2T);

	// pre-decrement steps down, every other update steps up
	assign ptr_next = (op != OP_PMR && mode == AM_PREDEC) ?
		ptr - PTR_STEP : ptr + PTR_STEP;

	// ---------------------------------------------------------------
	// bit unit
	// ---------------------------------------------------------------
	cbt_alu_if alu_if ();
	assign alu_if.op = op;
	assign alu_if.dst = gpr[rd];
	assign alu_if.src = gpr[rr];
	assign alu_if.bsel = bsel;
	assign alu_if.flags_in = flags_reg;
	cbt_alu cbt_alu_i (
		.alu(alu_if.alu)
	);

	// ---------------------------------------------------------------
	// data address generation
	// ---------------------------------------------------------------
	always_comb begin
		eff_addr = ptr;
		case (op)
			OP_IRD, OP_IWR: begin
				// decrement comes before the access
				if (mode == AM_PREDEC)
					eff_addr = ptr - PTR_STEP; // RQ7 RQ10
			end
			OP_DRD, OP_DWR: eff_addr = ptr + q_ext; // RQ8 RQ11
			OP_ARD, OP_AWR: eff_addr = operand_reg; // RQ12 RQ13
			OP_PUSH: eff_addr = sp_reg; // RQ15
			OP_POP: eff_addr = sp_reg + PTR_STEP; // RQ16
			default: begin
			end
		endcase
	end

	// ---------------------------------------------------------------
	// register write-back selection
	// ---------------------------------------------------------------
	always_comb begin
		we0 = 1'b0;
		wa0 = rd;
		wd0 = alu_if.result;
		pw_we = 1'b0;
		pw_idx = ptr_idx;
		pw_data = ptr_next;
		case (state_reg)
			S_ISSUE: begin
				case (op)
					OP_SSHR, OP_SWAP, OP_T2B, OP_CPY: we0 = 1'b1; // RQ2
					OP_CPYW: begin
						// pairs are even aligned, low byte at even index
						pw_we = 1'b1; // RQ22
						pw_idx = {rd[4:1], 1'b0};
						pw_data = {gpr[{rr[4:1], 1'b1}],
							gpr[{rr[4:1], 1'b0}]};
					end
					OP_IRD, OP_IWR: pw_we = (mode != AM_PLAIN); // RQ6 RQ9
					OP_PMR: pw_we = mode[PMR_INC_BIT]; // RQ14
					default: begin
					end
				endcase
			end
			S_ACCESS: begin
				// async data memory answers while the address stands
				we0 = is_dread; // RQ6 RQ12 RQ16
				wd0 = dm_rdata;
			end
			S_FETCH: begin
				we0 = 1'b1; // RQ14
				wa0 = mode[PMR_R0_BIT] ? R0_IDX : rd;
				wd0 = pm_rdata;
			end
			default: begin
			end
		endcase
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave: address phase capture, zero wait states
	// ---------------------------------------------------------------
	assign acc = hsel && htrans[HTRANS_ACT_BIT] && hready;
	assign bus_wr_ok = wr_pend_reg && !busy;
	assign start = bus_wr_ok && (wr_addr_reg == ADR_INSTR);

	// read data is chosen in the address phase; a read right behind a
	// write to the same word therefore still sees the old value
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[GPR_SEL_BIT]) begin
			rd_mux = {24'h00_0000, gpr[haddr[GPR_IDX_LSB +: 5]]};
		end else begin
			case (haddr[7:0])
				ADR_INSTR: rd_mux = 32'(instr_reg);
				ADR_OPERAND: rd_mux = {16'h0000, operand_reg};
				ADR_FLAGS: rd_mux = {24'h00_0000, flags_reg};
				ADR_STATUS: rd_mux = {29'h0000_0000, state_reg, busy};
				ADR_SP: rd_mux = {16'h0000, sp_reg};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// bus handshake registers; hsize is ignored, only words are used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
			hreadyout_reg <= 1'b1;
		end else begin
			wr_pend_reg <= acc && hwrite;
			hreadyout_reg <= 1'b1;
			if (acc)
				wr_addr_reg <= haddr[7:0];
			if (acc && !hwrite)
				hrdata_reg <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// instruction and operand registers
	// ---------------------------------------------------------------
	// writes while busy are dropped so a running op keeps its word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_reg <= '0;
			operand_reg <= 16'h0000;
		end else begin
			if (start)
				instr_reg <= hwdata[INSTR_W-1:0];
			if (bus_wr_ok && wr_addr_reg == ADR_OPERAND)
				operand_reg <= hwdata[15:0];
		end
	end

	// ---------------------------------------------------------------
	// sequencer: one edge for register ops, two for data memory,
	// three for program memory
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE: if (start) state_reg <= S_ISSUE;
				S_ISSUE: begin
					if (is_dread || is_dwrite || op == OP_PMR)
						state_reg <= S_ACCESS;
					else
						state_reg <= S_IDLE; // RQ1 RQ17 RQ21
				end
				S_ACCESS: begin
					if (op == OP_PMR)
						state_reg <= S_FETCH; // RQ14
					else
						state_reg <= S_IDLE; // RQ12 RQ13
				end
				S_FETCH: state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// working registers
	// ---------------------------------------------------------------
	// bus writes only land while idle, so they never race execution
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 32; i++)
				gpr[i] <= 8'h00;
		end else begin
			if (bus_wr_ok && wr_addr_reg[GPR_SEL_BIT])
				gpr[wr_addr_reg[GPR_IDX_LSB +: 5]] <= hwdata[7:0];
			if (we0)
				gpr[wa0] <= wd0;
			if (pw_we) begin
				gpr[pw_idx] <= pw_data[7:0]; // RQ6 RQ7 RQ9 RQ10
				gpr[{pw_idx[4:1], 1'b1}] <= pw_data[15:8];
			end
		end
	end

	// ---------------------------------------------------------------
	// flags register and stack pointer
	// ---------------------------------------------------------------
	// only bus writes and flag ops load flags; transfers and control leave them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			flags_reg <= FLAGS_RST;
		else if (bus_wr_ok && wr_addr_reg == ADR_FLAGS)
			flags_reg <= hwdata[7:0];
		else if (issue && is_flagop)
			flags_reg <= alu_if.flags_out; // RQ1 RQ3 RQ4 RQ5 RQ23
	end

	// save writes at sp then steps down; restore steps up first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sp_reg <= SP_RST;
		else if (bus_wr_ok && wr_addr_reg == ADR_SP)
			sp_reg <= hwdata[15:0];
		else if (issue && op == OP_PUSH)
			sp_reg <= sp_reg - PTR_STEP; // RQ15
		else if (issue && op == OP_POP)
			sp_reg <= sp_reg + PTR_STEP; // RQ16
	end

	// ---------------------------------------------------------------
	// memory strobes, held for the one access cycle
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dm_addr_reg <= 16'h0000;
			dm_wdata_reg <= 8'h00;
			dm_we_reg <= 1'b0;
			dm_re_reg <= 1'b0;
			pm_addr_reg <= 16'h0000;
			pm_re_reg <= 1'b0;
		end else begin
			dm_we_reg <= issue && is_dwrite; // RQ9 RQ11 RQ13 RQ15
			dm_re_reg <= issue && is_dread;
			pm_re_reg <= issue && (op == OP_PMR);
			if (issue) begin
				dm_addr_reg <= eff_addr;
				dm_wdata_reg <= gpr[rr];
				pm_addr_reg <= ptr; // RQ14
			end
		end
	end

	// ---------------------------------------------------------------
	// control pulses to power, watchdog and debug logic
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_reg <= 1'b0;
			wdt_reg <= 1'b0;
			brk_reg <= 1'b0;
		end else begin
			sleep_reg <= issue && (op == OP_SLEEP); // RQ17
			wdt_reg <= issue && (op == OP_WDOG); // RQ18
			// break carries no cycle promise; debug logic owns it
			brk_reg <= issue && (op == OP_BREAK); // RQ19
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign dm_addr = dm_addr_reg;
	assign dm_wdata = dm_wdata_reg;
	assign dm_we = dm_we_reg;
	assign dm_re = dm_re_reg;
	assign pm_addr = pm_addr_reg;
	assign pm_re = pm_re_reg;
	assign sleep_req = sleep_reg;
	assign wdt_restart = wdt_reg;
	assign debug_break = brk_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic src_bit; // bit picked by bit-to-flag
	logic [7:0] bit_mask;
	assign src_bit = gpr[rr][bsel];
	assign bit_mask = 8'h01 << bsel;

	sequence s_mem_two;
		state_reg == S_ACCESS ##1 state_reg == S_IDLE;
	endsequence
	sequence s_pm_three;
		pm_re_reg && state_reg == S_ACCESS ##1
		state_reg == S_FETCH ##1 state_reg == S_IDLE;
	endsequence

	property p_b2t;
		issue && op == OP_B2T |=> flags_reg[FL_T] == $past(src_bit) &&
			(flags_reg | (8'h01 << FL_T)) ==
			($past(flags_reg) | (8'h01 << FL_T)) && state_reg == S_IDLE;
	endproperty
	a_b2t: assert property (p_b2t) else $error("bit to T wrong"); // RQ1
	property p_t2b;
		issue && op == OP_T2B |=> $stable(flags_reg) &&
			gpr[rd][bsel] == $past(flags_reg[FL_T]);
	endproperty
	a_t2b: assert property (p_t2b) else $error("T to bit wrong"); // RQ2
	property p_fset;
		issue && op == OP_FSET |=>
			flags_reg == ($past(flags_reg) | $past(bit_mask));
	endproperty
	a_fset: assert property (p_fset) else $error("flag set"); // RQ3
	property p_fclr;
		issue && op == OP_FCLR |=>
			flags_reg == ($past(flags_reg) & ~$past(bit_mask));
	endproperty
	a_fclr: assert property (p_fclr) else $error("flag clear"); // RQ5
	property p_postinc;
		issue && op == OP_IRD && mode == AM_POSTINC |=>
			dm_re_reg && dm_addr_reg == $past(ptr) &&
			ptr == $past(ptr) + PTR_STEP ##0 s_mem_two;
	endproperty
	a_postinc: assert property (p_postinc) else $error("post inc"); // RQ6
	property p_predec;
		issue && op == OP_IRD && mode == AM_PREDEC |=>
			dm_addr_reg == ptr && ptr == $past(ptr) - PTR_STEP;
	endproperty
	a_predec: assert property (p_predec) else $error("pre dec"); // RQ7
	property p_disp;
		issue && op == OP_DRD |=> $stable(ptr) &&
			dm_addr_reg == $past(ptr) + $past(q_ext);
	endproperty
	a_disp: assert property (p_disp) else $error("displaced"); // RQ8
	property p_pmr;
		issue && op == OP_PMR |=> s_pm_three;
	endproperty
	a_pmr: assert property (p_pmr) else $error("pm read timing"); // RQ14
	property p_push;
		issue && op == OP_PUSH |=> dm_we_reg &&
			dm_addr_reg == $past(sp_reg) &&
			sp_reg == $past(sp_reg) - PTR_STEP && $stable(flags_reg);
	endproperty
	a_push: assert property (p_push) else $error("stack save"); // RQ15
	property p_wdog;
		issue && op == OP_WDOG |=> wdt_reg ##1 !wdt_reg;
	endproperty
	a_wdog: assert property (p_wdog) else $error("wdt pulse"); // RQ18
endmodule
`default_nettype wire

// ===== cbt_mem_model.sv
// data and program memory model facing cbt_core
// assumes one clock and the core's one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module cbt_mem_model (
	input wire logic hclk,
	input wire logic [15:0] dm_addr,
	input wire logic [7:0] dm_wdata,
	input wire logic dm_we,
	input wire logic dm_re,
	output logic [7:0] dm_rdata,
	input wire logic [15:0] pm_addr,
	input wire logic pm_re,
	output logic [7:0] pm_rdata
);
	logic [7:0] mem [65536]; // data space
	logic [7:0] prog [65536]; // program bytes
	logic [7:0] pm_q; // fetched byte
	logic pm_vld = 1'h0; // fetch valid this cycle
	// address-derived fill, so a wrong address reads a wrong byte
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
			prog[i] = i[7:0] ^ i[15:8] ^ 8'hc5;
		end
	end
	// outside a strobe the data is inverted, never left looking valid
	assign dm_rdata = dm_re ? mem[dm_addr] : ~mem[dm_addr];
	assign pm_rdata = pm_vld ? pm_q : ~pm_q;
	// write lands at the edge closing the strobe; fetch takes a cycle
	always @(posedge hclk) begin
		if (dm_we)
			mem[dm_addr] <= dm_wdata;
		if (pm_re)
			pm_q <= prog[pm_addr];
		pm_vld <= pm_re;
	end
endmodule
`default_nettype wire

// ===== cbt_core_tb.sv
// self-checking bench for cbt_core over its bus port
// assumes cbt_mem_model as memories and a zero-wait slave
`timescale 1ns/1ps
`default_nettype none
module cbt_core_tb;
	import cbt_pkg::*;
	logic hclk = 1'h0; // 50 ns period
	logic hresetn = 1'h0; // low for 12 cycles
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, dm_we, dm_re, pm_re;
	logic sleep_req, wdt_restart, debug_break;
	logic [31:0] hrdata, rq; // rq: last read word
	logic [15:0] dm_addr, pm_addr;
	logic [7:0] dm_wdata, dm_rdata, pm_rdata;
	logic [7:0] ef; // expected flags
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0; // hang guard
	int pulses [3] = '{0, 0, 0}; // strobe cycles: sleep, watchdog, break
	int pc [3];
	int fb [4] = '{FL_V, FL_S, FL_H, FL_I};
	cbt_op_t cop [3] = '{OP_SLEEP, OP_WDOG, OP_BREAK};
	always #25 hclk = ~hclk;
	cbt_core #(.SP_RST(SP_RST_DEF)) cbt_core_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
		.dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
		.pm_addr(pm_addr), .pm_re(pm_re), .pm_rdata(pm_rdata),
		.sleep_req(sleep_req), .wdt_restart(wdt_restart),
		.debug_break(debug_break)
	);
	cbt_mem_model cbt_mem_model_i (
		.hclk(hclk), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
		.dm_re(dm_re), .dm_rdata(dm_rdata), .pm_addr(pm_addr),
		.pm_re(pm_re), .pm_rdata(pm_rdata)
	);
	// count strobe cycles; a run past the ceiling is a hang
	always @(posedge hclk) begin
		pulses[0] <= pulses[0] + sleep_req;
		pulses[1] <= pulses[1] + wdt_restart;
		pulses[2] <= pulses[2] + debug_break;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	// one single transfer; entered right after an edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d, rq);
	endtask
	task automatic rc(input string w, input logic [7:0] a, logic [31:0] e);
		bus(1'h0, a, 32'h0, rq);
		chk(w, e, rq);
	endtask
	// wait, bounded, until the busy bit drops
	task automatic wt();
		repeat (10) begin
			bus(1'h0, ADR_STATUS, 32'h0, rq);
			if (rq[0] === 1'h0)
				break;
		end
		chk("idle", 32'h0, {31'h0, rq[0]});
	endtask
	task automatic exec(input logic [31:0] w);
		wr(ADR_INSTR, w);
		wt();
	endtask
	// pm holds {mode, pointer}
	function automatic logic [31:0] ins(input cbt_op_t op,
		input logic [4:0] rd, rr, input logic [2:0] b, input logic [3:0] pm);
		return {4'h0, pm, b, rr, 3'h0, rd, 3'h0, op};
	endfunction
	function automatic logic [7:0] ga(input logic [4:0] n);
		return {1'h1, n, 2'h0};
	endfunction
	function automatic logic [31:0] mm(input logic [15:0] a);
		return {24'h0, cbt_mem_model_i.mem[a]};
	endfunction
	task automatic setp(input logic [4:0] lo, input logic [15:0] v);
		wr(ga(lo), {24'h0, v[7:0]});
		wr(ga(lo + 5'h1), {24'h0, v[15:8]});
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		rc("flags", ADR_FLAGS, 32'h0);
		rc("sp", ADR_SP, {16'h0, SP_RST_DEF});
		wr(8'h40, 32'hffff_ffff);
		rc("unmapped", 8'h40, 32'h0);
		ef = FLAGS_RST;
		for (int s = 1; s >= 0; s--) begin
			foreach (fb[i]) begin
				exec(ins(cbt_op_t'(s ? OP_FSET : OP_FCLR), 5'h0, 5'h0,
					fb[i][2:0], 4'h0));
				ef[fb[i]] = s[0];
				rc("flag", ADR_FLAGS, {24'h0, ef});
			end
		end
		wr(ga(5'h10), 32'h96);
		wr(ADR_FLAGS, 32'h75);
		exec(ins(OP_B2T, 5'h10, 5'h10, 3'h0, 4'h0));
		rc("t low", ADR_FLAGS, 32'h35);
		exec(ins(OP_B2T, 5'h10, 5'h10, 3'h2, 4'h0));
		rc("t high", ADR_FLAGS, 32'h75);
		exec(ins(OP_T2B, 5'h11, 5'h11, 3'h3, 4'h0));
		rc("bit from t", ga(5'h11), 32'h08);
		exec(ins(OP_SSHR, 5'h10, 5'h10, 3'h0, 4'h0));
		rc("shift", ga(5'h10), 32'hcb);
		rc("shift flags", ADR_FLAGS, 32'h7c);
		exec(ins(OP_SWAP, 5'h10, 5'h10, 3'h0, 4'h0));
		rc("swap", ga(5'h10), 32'hbc);
		exec(ins(OP_CPY, 5'h12, 5'h10, 3'h0, 4'h0));
		rc("copy", ga(5'h12), 32'hbc);
		exec(ins(OP_CPYW, 5'h14, 5'h10, 3'h0, 4'h0));
		rc("pair lo", ga(5'h14), 32'hbc);
		rc("pair hi", ga(5'h15), 32'h08);
		rc("flags kept", ADR_FLAGS, 32'h7c);
		setp(5'h1a, 16'h0123);
		exec(ins(OP_IRD, 5'h01, 5'h01, 3'h0, 4'h4));
		rc("load x+", ga(5'h01), mm(16'h0123));
		rc("x after", ga(5'h1a), 32'h24);
		setp(5'h1c, 16'h0200);
		exec(ins(OP_IRD, 5'h02, 5'h02, 3'h0, 4'h9));
		rc("load -y", ga(5'h02), mm(16'h01ff));
		rc("y hi", ga(5'h1d), 32'h01);
		setp(5'h1e, 16'h0300);
		wr(ADR_OPERAND, 32'h5);
		exec(ins(OP_DRD, 5'h03, 5'h03, 3'h0, 4'h2));
		rc("load z+q", ga(5'h03), mm(16'h0305));
		rc("z kept", ga(5'h1e), 32'h0);
		wr(ADR_OPERAND, 32'h0456);
		exec(ins(OP_ARD, 5'h04, 5'h04, 3'h0, 4'h0));
		rc("direct load", ga(5'h04), mm(16'h0456));
		exec(ins(OP_IWR, 5'h10, 5'h10, 3'h0, 4'h4));
		chk("store x+", 32'hbc, mm(16'h0124));
		rc("x next", ga(5'h1a), 32'h25);
		exec(ins(OP_IWR, 5'h11, 5'h11, 3'h0, 4'h9));
		chk("store -y", 32'h08, mm(16'h01fe));
		rc("y next", ga(5'h1c), 32'hfe);
		wr(ADR_OPERAND, 32'h9);
		exec(ins(OP_DWR, 5'h10, 5'h10, 3'h0, 4'h2));
		chk("store z+q", 32'hbc, mm(16'h0309));
		wr(ADR_OPERAND, 32'h0777);
		exec(ins(OP_AWR, 5'h11, 5'h11, 3'h0, 4'h0));
		chk("direct store", 32'h08, mm(16'h0777));
		exec(ins(OP_PUSH, 5'h10, 5'h10, 3'h0, 4'h0));
		chk("push", 32'hbc, mm(16'h01ff));
		rc("sp down", ADR_SP, 32'h01fe);
		exec(ins(OP_POP, 5'h06, 5'h06, 3'h0, 4'h0));
		rc("pop", ga(5'h06), 32'hbc);
		rc("sp up", ADR_SP, 32'h01ff);
		// a register write landing mid-fetch must be dropped
		wr(ADR_INSTR, ins(OP_PMR, 5'h09, 5'h09, 3'h0, 4'ha));
		wr(ADR_FLAGS, 32'hff);
		wt();
		rc("fetch r0", ga(5'h00), {24'h0, cbt_mem_model_i.prog[16'h0300]});
		exec(ins(OP_PMR, 5'h07, 5'h07, 3'h0, 4'h6));
		rc("fetch z+", ga(5'h07), {24'h0, cbt_mem_model_i.prog[16'h0300]});
		rc("z next", ga(5'h1e), 32'h01);
		foreach (cop[i]) begin
			pc = pulses;
			exec(ins(cop[i], 5'h0, 5'h0, 3'h0, 4'h0));
			foreach (pc[j])
				chk("strobe", i == j, pulses[j] - pc[j]);
		end
		rc("flags end", ADR_FLAGS, 32'h7c);
		chk("hresp", 32'h0, {31'h0, hresp});
		final_report();
	end
endmodule
`default_nettype wire
